/* File: hw/ses_map.svh */
// Purpose: opcodes, field positions and timing figures of the serial eeprom sequencer
// Assumes: included by the package and the sequencer module
// Notes: definitions only
`ifndef SES_MAP_SVH
`define SES_MAP_SVH

// bit 3 of every opcode is don't-care and is masked off before decode
`define SES_OP_MASK 8'hf7
`define SES_OP_SET_WEL 8'h06
`define SES_OP_CLR_WEL 8'h04
`define SES_OP_STATUS_RD 8'h05
`define SES_OP_STATUS_WR 8'h01
`define SES_OP_READ 8'h03
`define SES_OP_WRITE 8'h02

// serial field lengths
`define SES_OP_LAST 4'h7
`define SES_ADDR_LAST 4'hf
`define SES_PAGE_BITS 5

// status byte layout
`define SES_SR_WIP 0
`define SES_SR_WEL 1
`define SES_SR_BP_LO 2
`define SES_SR_BP_HI 3

// self-timed programming cycle
`define SES_WRITE_TIME_US 5
`define SES_CLK_MHZ 25

// two-stage synchroniser lanes
`define SES_LANE_SCK 0
`define SES_LANE_CS 1
`define SES_LANE_SI 2

`endif

/* File: hw/ses_pkg.sv */
// Purpose: shared types of the serial eeprom sequencer
// Assumes: ses_map.svh gives the field widths
// Notes: nothing here is imported; users write ses_pkg::name
`include "ses_map.svh"

package ses_pkg;

    // serial transaction phases
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_ADDR,
        ST_READ,
        ST_STATUS,
        ST_WDATA,
        ST_WSR,
        ST_IGNORE
    } ses_state_t;

    // decoded opcodes
    typedef enum logic [2:0] {
        CMD_SET_WEL,
        CMD_CLR_WEL,
        CMD_STATUS_RD,
        CMD_STATUS_WR,
        CMD_READ,
        CMD_WRITE,
        CMD_BAD
    } ses_cmd_t;

    // one received data byte and its slot in the page
    typedef struct packed {
        logic [`SES_PAGE_BITS-1:0] idx;
        logic [7:0] data;
    } ses_wbyte_t;

endpackage : ses_pkg

/* File: hw/ses_buf2.sv */
// Purpose: small valid/ready buffer between the serial receiver and the page loader
// Assumes: single clock, asynchronous active-low reset
// Notes: DEPTH of two lets two words wait while the drain side stalls
`timescale 1ns/100ps

module ses_buf2 #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,              // system clock
    input wire logic arst_n_i,           // asynchronous reset, active low
    input wire logic in_valid_i,         // word offered
    output logic in_ready_o,             // room for a word
    input wire logic [WIDTH-1:0] in_data_i, // word in
    output logic out_valid_o,            // word available
    input wire logic out_ready_i,        // drain takes the word
    output logic [WIDTH-1:0] out_data_o, // word out
    output logic empty_o                 // nothing stored
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW:0] count;
    logic push;
    logic pop;

    // honest flags straight from the occupancy count
    assign in_ready_o = (count != (PW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign empty_o = (count == '0);
    assign out_data_o = store[rptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // storage, no reset needed on data
    always_ff @(posedge clk_i) begin
        if (push) begin
            store[wptr] <= in_data_i;
        end
    end

    // pointers wrap at DEPTH
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wptr <= (wptr == PW'(DEPTH-1)) ? '0 : wptr + 1'b1;
            end
            if (pop) begin
                rptr <= (rptr == PW'(DEPTH-1)) ? '0 : rptr + 1'b1;
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

endmodule : ses_buf2

/* File: hw/ses_eeprom.sv */
// Purpose: command sequencer of a serial eeprom behind a four-wire mode-0 link
// Assumes: link pins are asynchronous to clk_i; link clock well below clk_i / 4
// Notes: array, page buffer and protection bits live here; no software registers
`timescale 1ns/100ps
`include "ses_map.svh"

// Summary of operation
// - read opcode then 16-bit address; only low array bits are used.
// - after read address, serial_in ignored; addressed byte shifted out MSB first.
// - while selected, address increments after each byte and reading continues.
// - read address wraps from highest array address to zero.
// - only bytes outside the block-protected region are programmed.
// - during a programming cycle only status read is executed.
// - programming starts at chip select rise after a valid write, not before.
// - status bit 0 reads 1 while programming runs, 0 afterwards.
// - page of up to 32 bytes; only five low address bits increment.
// - beyond 32 bytes the page index wraps and later bytes replace earlier.
// - write enable latch clears itself when programming completes.
// - write with latch clear is dropped; a fresh select is needed.
// - 8-bit opcodes with bit 3 don't-care select the six commands.
// - every opcode, address and data bit travels MSB first.
// - unknown opcode: nothing more taken, output stays off until reselect.
// - status bit 1 shows the write enable latch.
module ses_eeprom #(
    parameter int ARRAY_ADDR_W = 13,
    parameter int WRITE_CYCLES = `SES_WRITE_TIME_US * `SES_CLK_MHZ
) (
    input wire logic clk_i,           // system clock, 25 MHz
    input wire logic arst_n_i,        // asynchronous reset, active low
    input wire logic spi_clk_i,       // link serial clock from the master
    input wire logic chip_sel_n_i,    // chip select, active low
    input wire logic serial_in_i,     // serial data from the master
    output logic serial_out_o,        // serial data to the master
    output logic serial_out_oe_o,     // high while serial_out_o is driven
    output logic write_busy_o         // programming cycle running
);
    localparam int PAGE_BYTES = 1 << `SES_PAGE_BITS;
    localparam int WCW = $clog2(WRITE_CYCLES + 1);
    localparam int PW = `SES_PAGE_BITS;

    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] prev;
    logic sck_rise;
    logic sck_fall;
    logic cs_hi;
    logic cs_rise;
    logic in_bit;
    ses_pkg::ses_state_t st;
    logic [3:0] cnt;
    logic [15:0] sh;
    logic [15:0] sh_next;
    logic got_byte;
    logic addr_wr;
    logic [7:0] sr_val;
    logic [PW-1:0] page_ptr;
    logic [ARRAY_ADDR_W-1:0] wr_base;
    logic [ARRAY_ADDR_W-1:0] rd_addr;
    logic [7:0] out_sh;
    logic [2:0] ocnt;
    logic wel;
    logic [1:0] bp;
    logic busy;
    logic kind_sr;
    logic pend_data;
    logic pend_sr;
    logic [WCW-1:0] wcnt;
    logic [7:0] mem [2**ARRAY_ADDR_W];
    logic [7:0] page_data [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] page_vld;
    logic cmd_done;
    ses_pkg::ses_cmd_t cmd;
    logic addr_done;
    logic byte_done;
    logic commit_data;
    logic commit_sr;
    logic start_prog;
    logic end_prog;
    logic [PW-1:0] prog_idx;
    logic [7:0] status_byte;
    ses_pkg::ses_wbyte_t push_word;
    ses_pkg::ses_wbyte_t drain_word;
    logic push_ready;
    logic drain_valid;
    logic buf_empty;

    // opcode decode with the don't-care bit masked out
    function automatic ses_pkg::ses_cmd_t decode(input logic [7:0] op);
        unique case (op & `SES_OP_MASK)
            `SES_OP_SET_WEL: decode = ses_pkg::CMD_SET_WEL;
            `SES_OP_CLR_WEL: decode = ses_pkg::CMD_CLR_WEL;
            `SES_OP_STATUS_RD: decode = ses_pkg::CMD_STATUS_RD;
            `SES_OP_STATUS_WR: decode = ses_pkg::CMD_STATUS_WR;
            `SES_OP_READ: decode = ses_pkg::CMD_READ;
            `SES_OP_WRITE: decode = ses_pkg::CMD_WRITE;
            default: decode = ses_pkg::CMD_BAD;
        endcase
    endfunction : decode

    // top quarter, top half or whole array, by protection level
    function automatic logic is_protected(input logic [ARRAY_ADDR_W-1:0] a,
                                          input logic [1:0] lvl);
        unique case (lvl)
            2'h0: is_protected = 1'b0;
            2'h1: is_protected = &a[ARRAY_ADDR_W-1 -: 2];
            2'h2: is_protected = a[ARRAY_ADDR_W-1];
            2'h3: is_protected = 1'b1;
        endcase
    endfunction : is_protected

    // two synchroniser flops and one edge flop per link pin; the first stage is never looked at
    generate
        for (genvar g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    sync1[g] <= (g == `SES_LANE_CS) ? 1'b1 : 1'b0;
                    sync2[g] <= (g == `SES_LANE_CS) ? 1'b1 : 1'b0;
                    prev[g] <= (g == `SES_LANE_CS) ? 1'b1 : 1'b0;
                end else begin
                    sync1[g] <= (g == `SES_LANE_SCK) ? spi_clk_i :
                                (g == `SES_LANE_CS) ? chip_sel_n_i : serial_in_i;
                    sync2[g] <= sync1[g];
                    prev[g] <= sync2[g];
                end
            end
        end
    endgenerate

    // mode 0 edges of the link clock
    assign sck_rise = sync2[`SES_LANE_SCK] && !prev[`SES_LANE_SCK];
    assign sck_fall = !sync2[`SES_LANE_SCK] && prev[`SES_LANE_SCK];
    assign cs_hi = sync2[`SES_LANE_CS];
    assign cs_rise = sync2[`SES_LANE_CS] && !prev[`SES_LANE_CS];
    assign in_bit = sync2[`SES_LANE_SI];
    assign sh_next = {sh[14:0], in_bit};

    // decode strobes taken on the last bit of each field
    assign cmd_done = (st == ses_pkg::ST_CMD) && sck_rise && (cnt == `SES_OP_LAST);
    assign cmd = decode(sh_next[7:0]);
    assign addr_done = (st == ses_pkg::ST_ADDR) && sck_rise && (cnt == `SES_ADDR_LAST);
    assign byte_done = sck_rise && (cnt == `SES_OP_LAST);
    // a write counts only if select rises on a byte boundary
    assign commit_data = cs_rise && (st == ses_pkg::ST_WDATA) && (cnt == 4'h0)
                         && got_byte;
    assign commit_sr = cs_rise && (st == ses_pkg::ST_WSR) && (cnt == 4'h0) && got_byte;
    // programming waits until the buffer has handed over every byte
    assign start_prog = !busy && buf_empty && (pend_data || pend_sr);
    assign end_prog = busy && (wcnt == WCW'(WRITE_CYCLES - 1));
    assign prog_idx = wcnt[PW-1:0];

    // serial phase machine, one step per rising link clock edge
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= ses_pkg::ST_IDLE;
            cnt <= 4'h0;
            sh <= 16'h0000;
            got_byte <= 1'b0;
            addr_wr <= 1'b0;
            sr_val <= 8'h00;
            page_ptr <= '0;
            wr_base <= '0;
        end else if (cs_hi) begin
            st <= ses_pkg::ST_IDLE;
            cnt <= 4'h0;
        end else if (st == ses_pkg::ST_IDLE) begin
            // only a fresh select leaves idle, so ignored phases need reselect
            st <= ses_pkg::ST_CMD;
            cnt <= 4'h0;
            got_byte <= 1'b0;
        end else if (sck_rise) begin
            sh <= sh_next;
            cnt <= cnt + 4'h1;
            unique case (st)
                ses_pkg::ST_CMD: begin
                    if (cnt == `SES_OP_LAST) begin
                        cnt <= 4'h0;
                        // the opcode is shifted out of sh by the address, so keep its kind
                        addr_wr <= (cmd == ses_pkg::CMD_WRITE);
                        if (busy && cmd != ses_pkg::CMD_STATUS_RD) begin
                            st <= ses_pkg::ST_IGNORE;
                        end else begin
                            unique case (cmd)
                                ses_pkg::CMD_READ: st <= ses_pkg::ST_ADDR;
                                ses_pkg::CMD_WRITE: st <= wel ? ses_pkg::ST_ADDR
                                                              : ses_pkg::ST_IGNORE;
                                ses_pkg::CMD_STATUS_RD: st <= ses_pkg::ST_STATUS;
                                ses_pkg::CMD_STATUS_WR: st <= wel ? ses_pkg::ST_WSR
                                                                  : ses_pkg::ST_IGNORE;
                                default: st <= ses_pkg::ST_IGNORE;
                            endcase
                        end
                    end
                end
                ses_pkg::ST_ADDR: begin
                    if (cnt == `SES_ADDR_LAST) begin
                        cnt <= 4'h0;
                        // upper address bits are don't-care
                        wr_base <= sh_next[ARRAY_ADDR_W-1:0];
                        page_ptr <= sh_next[PW-1:0];
                        st <= addr_wr ? ses_pkg::ST_WDATA : ses_pkg::ST_READ;
                    end
                end
                ses_pkg::ST_WDATA: begin
                    if (cnt == `SES_OP_LAST) begin
                        cnt <= 4'h0;
                        got_byte <= 1'b1;
                        page_ptr <= page_ptr + 1'b1;
                    end
                end
                ses_pkg::ST_WSR: begin
                    if (cnt == `SES_OP_LAST) begin
                        cnt <= 4'h0;
                        got_byte <= 1'b1;
                        sr_val <= sh_next[7:0];
                    end
                end
                default: begin
                    cnt <= 4'h0;
                end
            endcase
        end
    end

    // received data bytes wait here until the page loader takes them
    assign push_word.idx = page_ptr;
    assign push_word.data = sh_next[7:0];

    ses_buf2 #(
        .WIDTH($bits(ses_pkg::ses_wbyte_t)),
        .DEPTH(2)
    ) u_buf (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .in_valid_i((st == ses_pkg::ST_WDATA) && byte_done),
        .in_ready_o(push_ready),
        .in_data_i(push_word),
        .out_valid_o(drain_valid),
        .out_ready_i(!busy),
        .out_data_o(drain_word),
        .empty_o(buf_empty)
    );

    // page loader: later bytes in the same slot overwrite earlier ones
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            page_vld <= '0;
        end else if (end_prog || (st == ses_pkg::ST_IDLE && !cs_hi && !busy)) begin
            page_vld <= '0;
        end else if (drain_valid && !busy) begin
            page_vld[drain_word.idx] <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (drain_valid && !busy) begin
            page_data[drain_word.idx] <= drain_word.data;
        end
    end

    // self-timed programming cycle; the array is walked during its first slots
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy <= 1'b0;
            kind_sr <= 1'b0;
            pend_data <= 1'b0;
            pend_sr <= 1'b0;
            wcnt <= '0;
            bp <= 2'h0;
        end else begin
            if (commit_data && push_ready) begin
                pend_data <= 1'b1;
            end
            if (commit_sr) begin
                pend_sr <= 1'b1;
            end
            if (start_prog) begin
                busy <= 1'b1;
                wcnt <= '0;
                kind_sr <= pend_sr;
                pend_data <= 1'b0;
                pend_sr <= 1'b0;
                if (pend_sr) begin
                    bp <= {sr_val[`SES_SR_BP_HI], sr_val[`SES_SR_BP_LO]};
                end
            end else if (end_prog) begin
                busy <= 1'b0;
            end else if (busy) begin
                wcnt <= wcnt + 1'b1;
            end
        end
    end

    // array update; protected locations are skipped
    always_ff @(posedge clk_i) begin
        if (busy && !kind_sr && wcnt < WCW'(PAGE_BYTES) && page_vld[prog_idx]
            && !is_protected({wr_base[ARRAY_ADDR_W-1:PW], prog_idx}, bp)) begin
            mem[{wr_base[ARRAY_ADDR_W-1:PW], prog_idx}] <= page_data[prog_idx];
        end
    end

    // write enable latch: commands while idle, self-clear at cycle end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wel <= 1'b0;
        end else if (end_prog) begin
            wel <= 1'b0;
        end else if (cmd_done && !busy && cmd == ses_pkg::CMD_SET_WEL) begin
            wel <= 1'b1;
        end else if (cmd_done && !busy && cmd == ses_pkg::CMD_CLR_WEL) begin
            wel <= 1'b0;
        end
    end

    // status byte as shifted out
    always_comb begin
        status_byte = 8'h00;
        status_byte[`SES_SR_WIP] = busy;
        status_byte[`SES_SR_WEL] = wel;
        status_byte[`SES_SR_BP_LO] = bp[0];
        status_byte[`SES_SR_BP_HI] = bp[1];
    end

    // output shifter, changes only after falling link clock edges
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            serial_out_o <= 1'b0;
            serial_out_oe_o <= 1'b0;
            out_sh <= 8'h00;
            ocnt <= 3'h0;
            rd_addr <= '0;
        end else if (cs_hi) begin
            serial_out_oe_o <= 1'b0;
            ocnt <= 3'h0;
        end else if (addr_done) begin
            rd_addr <= sh_next[ARRAY_ADDR_W-1:0];
        end else if (sck_fall && (st == ses_pkg::ST_READ || st == ses_pkg::ST_STATUS)) begin
            serial_out_oe_o <= 1'b1;
            ocnt <= ocnt + 3'h1;
            if (ocnt == 3'h0) begin
                if (st == ses_pkg::ST_READ) begin
                    serial_out_o <= mem[rd_addr][7];
                    out_sh <= {mem[rd_addr][6:0], 1'b0};
                    rd_addr <= rd_addr + 1'b1;
                end else begin
                    serial_out_o <= status_byte[7];
                    out_sh <= {status_byte[6:0], 1'b0};
                end
            end else begin
                serial_out_o <= out_sh[7];
                out_sh <= {out_sh[6:0], 1'b0};
            end
        end
    end

    // busy is visible for observation
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            write_busy_o <= 1'b0;
        end else begin
            write_busy_o <= busy;
        end
    end

endmodule : ses_eeprom

/* File: verification/ses_eeprom_props.sv */
// Purpose: pin timing checks for the eeprom sequencer
// Assumes: bound to ses_eeprom from tb; link phases last 4 clk
// Notes: sees only the top ports
`timescale 1ns/100ps
module ses_eeprom_props #(
    parameter int WRITE_CYCLES = 125
) (
    input wire logic clk_i,           // system clock
    input wire logic arst_n_i,        // reset, active low
    input wire logic spi_clk_i,       // link clock
    input wire logic chip_sel_n_i,    // chip select, active low
    input wire logic serial_in_i,     // link data in
    input wire logic serial_out_o,    // link data out
    input wire logic serial_out_oe_o, // out enable
    input wire logic write_busy_o     // programming cycle
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    logic [2:0] cs_hi;
    int busy_len;
    // deselect time, saturating so a long idle cannot wrap back to zero
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cs_hi <= 3'h0;
        end else if (!chip_sel_n_i) begin
            cs_hi <= 3'h0;
        end else if (cs_hi != 3'h7) begin
            cs_hi <= cs_hi + 3'h1;
        end
    end
    // length of the current programming cycle
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_len <= 0;
        end else begin
            busy_len <= write_busy_o ? busy_len + 1 : 0;
        end
    end
    property p_idle_quiet;
        cs_hi >= 3'h6 |-> !serial_out_oe_o;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("out driven while deselected");
    property p_prog_start;
        $rose(write_busy_o) |-> chip_sel_n_i && $past(chip_sel_n_i, 3);
    endproperty
    a_prog_start: assert property (p_prog_start) else $error("programming before deselect");
    property p_prog_len;
        $fell(write_busy_o) |-> busy_len >= WRITE_CYCLES - 2 && busy_len <= WRITE_CYCLES + 2;
    endproperty
    a_prog_len: assert property (p_prog_len) else $error("programming length off");
    property p_prog_min;
        $rose(write_busy_o) |=> write_busy_o [*8];
    endproperty
    a_prog_min: assert property (p_prog_min) else $error("programming cut short");
    property p_out_after_fall;
        serial_out_oe_o && $past(serial_out_oe_o) && $changed(serial_out_o)
            |-> !spi_clk_i && !$past(spi_clk_i, 2);
    endproperty
    a_out_after_fall: assert property (p_out_after_fall) else $error("out moved off fall");
    property p_out_steady;
        serial_out_oe_o && spi_clk_i && $past(spi_clk_i) |-> $stable(serial_out_o);
    endproperty
    a_out_steady: assert property (p_out_steady) else $error("out moved in high phase");
    property p_oe_in_frame;
        $rose(serial_out_oe_o) |-> !chip_sel_n_i && !spi_clk_i;
    endproperty
    a_oe_in_frame: assert property (p_oe_in_frame) else $error("out enabled off frame");
    property p_oe_to_end;
        $fell(serial_out_oe_o) |-> chip_sel_n_i && $past(chip_sel_n_i, 2);
    endproperty
    a_oe_to_end: assert property (p_oe_to_end) else $error("stream stopped in frame");
    c_prog: cover property ($rose(write_busy_o));
    c_stream: cover property ($rose(serial_out_oe_o));
    c_status_busy: cover property (write_busy_o && serial_out_oe_o);
endmodule : ses_eeprom_props

/* File: verification/ses_host_model.sv */
// Purpose: mode-0 link master driving the eeprom sequencer
// Assumes: 320 ns link period, 4 clk per phase
// Notes: link clock rests low outside frames
`timescale 1ns/100ps
module ses_host_model (
    input wire logic clk_i,   // system clock
    input wire logic so_i,    // device data out
    input wire logic so_oe_i, // device out enable
    output logic spi_clk_o,   // link clock
    output logic cs_n_o,      // chip select, active low
    output logic si_o         // data to device
);
    logic last;
    initial begin
        spi_clk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        last = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic sel();
        cs_n_o = 1'b0; // frame opens
        tick(4);
    endtask : sel
    // deselect in the low phase after a whole byte; data line left toggling
    task automatic desel();
        tick(2);
        cs_n_o = 1'b1; // end of frame
        si_o = ~si_o;
        tick(6);
    endtask : desel
    // an undriven out line reads as junk, never as the last bit
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si_o = tx[i]; // msb first
            tick(4);
            spi_clk_o = 1'b1; // sample on rise
            last = so_oe_i ? so_i : ~last;
            rx[i] = last;
            tick(4);
            spi_clk_o = 1'b0;
        end
    endtask : xfer
endmodule : ses_host_model

/* File: verification/tb.sv */
// Purpose: self-checking bench of the eeprom sequencer
// Assumes: host model drives the link
// Notes: programming cycle of 600 clk, longer than the 125 clk default
`timescale 1ns/100ps
module tb;
    localparam int WC = 600;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic sck, cs_n, si, so, so_oe, busy;
    logic [7:0] rx, s;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #20 clk_i = ~clk_i;
    ses_eeprom #(.WRITE_CYCLES(WC)) uut (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .spi_clk_i(sck), .chip_sel_n_i(cs_n), .serial_in_i(si), .serial_out_o(so),
        .serial_out_oe_o(so_oe), .write_busy_o(busy));
    ses_host_model host (.clk_i(clk_i), .so_i(so), .so_oe_i(so_oe), .spi_clk_o(sck),
        .cs_n_o(cs_n), .si_o(si));
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk8
    // a hang is cut short here
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic op(input logic [7:0] c);
        host.sel();
        host.xfer(c, rx);
        host.desel();
    endtask : op
    task automatic start(input logic [7:0] c, input logic [15:0] a);
        host.sel();
        host.xfer(c, rx);
        host.xfer(a[15:8], rx);
        host.xfer(a[7:0], rx);
    endtask : start
    task automatic status(output logic [7:0] v);
        host.sel();
        host.xfer(8'h05, rx);
        host.xfer(8'h00, v);
        host.desel();
    endtask : status
    task automatic wait_idle();
        host.tick(8);
        for (int i = 0; i < 1000 && busy !== 1'b0; i++) host.tick(1);
        chk8({7'h0, busy}, 8'h00, "still busy");
    endtask : wait_idle
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        start(8'h02, a);
        host.xfer(d, rx);
        host.desel();
    endtask : wr
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        start(8'h03, a);
        host.xfer(8'hff, rx);
        host.desel();
        chk8(rx, exp, "single read");
    endtask : rd_chk
    task automatic status_write_cmd(input logic [7:0] v);
        op(8'h06); // latch first
        host.sel();
        host.xfer(8'h01, rx);
        host.xfer(v, rx);
        host.desel();
        wait_idle();
        status(s);
        chk8(s, v & 8'h0c, "status after write"); // latch cleared
    endtask : status_write_cmd
    // 34 bytes into the top page, then a status poll and a read while it programs
    task automatic t_page();
        op(8'h06);
        status(s);
        chk8(s, 8'h02, "latch bit");
        start(8'h02, 16'hfffe); // high bits ignored
        for (int k = 0; k < 34; k++) host.xfer(8'h40 + 8'(k), rx);
        host.desel();
        status(s);
        chk8(s & 8'h01, 8'h01, "busy bit");
        start(8'h03, 16'h0000);
        host.xfer(8'h00, rx);
        chk8({7'h0, so_oe}, 8'h00, "read while busy");
        host.desel();
        wait_idle();
        op(8'h06);
        start(8'h02, 16'h0000);
        host.xfer(8'h11, rx);
        host.xfer(8'h22, rx);
        host.desel();
        wait_idle();
    endtask : t_page
    task automatic t_read_wrap();
        logic [7:0] exp[4] = '{8'h60, 8'h61, 8'h11, 8'h22};
        start(8'h0b, 16'h3ffe); // bit 3 ignored
        foreach (exp[i]) begin
            host.xfer(8'ha5, rx);
            chk8(rx, exp[i], "stream");
        end
        host.desel();
    endtask : t_read_wrap
    task automatic t_refused();
        op(8'h06);
        op(8'h04);
        status(s);
        chk8(s, 8'h00, "latch cleared");
        wr(16'h0000, 8'h99);
        host.tick(12);
        chk8({7'h0, busy}, 8'h00, "write without latch");
        rd_chk(16'h0000, 8'h11);
        status_write_cmd(8'h0c);
        op(8'h06);
        wr(16'h0001, 8'h77);
        wait_idle();
        rd_chk(16'h0001, 8'h22);
        status_write_cmd(8'h00);
        start(8'hff, 16'h0500);
        host.xfer(8'h00, rx);
        chk8({7'h0, so_oe}, 8'h00, "bad opcode");
        host.desel();
    endtask : t_refused
    initial begin
        host.tick(2);
        arst_n_i = 1'b1;
        host.tick(4);
        status_write_cmd(8'h00);
        t_page();
        t_read_wrap();
        t_refused();
        tally_and_finish();
    end
endmodule : tb
bind ses_eeprom ses_eeprom_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .spi_clk_i(spi_clk_i), .chip_sel_n_i(chip_sel_n_i),
    .serial_in_i(serial_in_i), .serial_out_o(serial_out_o),
    .serial_out_oe_o(serial_out_oe_o), .write_busy_o(write_busy_o));
